// [rtl/psme_engine.sv]
// Management command register and serial frame engine.
module psme_engine #(
	parameter int DIV = psme_pkg::MDC_DIV
) (
	// System clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Register access port
	input psme_pkg::psme_bus_req_t bus_req,
	output logic [31:0] reg_rdata,
	output logic reg_rvalid,
	// Cycle interrupt
	output logic cycle_irq,
	// Link clock
	input wire logic serial_clk,
	// Station management pins
	output logic mdc,
	input wire logic mdio_in,
	output logic mdio_out,
	output logic mdio_oe
);
	import psme_pkg::*;

	typedef enum logic [1:0] {
		LK_IDLE,
		LK_SHIFT,
		LK_TAIL
	} psme_link_state_t;

	localparam int PW = $clog2(DIV);
	localparam logic [PW-1:0] HALF = PW'(DIV / 2);
	localparam logic [5:0] LAST_BIT = 6'(FRAME_BITS - 1);
	localparam logic [5:0] DRIVEN_LIMIT = 6'(READ_DRIVEN_BITS);
	localparam logic [5:0] DATA_FIRST = 6'(READ_DATA_FIRST);

	// Divider must respect the clock ceiling and split into two equal halves
	if (DIV < MDC_DIV) begin : g_div_too_small
		$error("psme_engine: DIV too small for the clock ceiling");
	end
	if (DIV % 2 != 0) begin : g_div_odd
		$error("psme_engine: DIV must be even");
	end

	// Merge a byte-enabled write into a word
	function automatic logic [31:0] merge_lanes(input logic [31:0] old_word, input logic [31:0] new_word,
			input logic [3:0] be);
		logic [31:0] result;
		result = old_word;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				result[8*i +: 8] = new_word[8*i +: 8];
			end
		end
		return result;
	endfunction

	// Build the outgoing frame bits
	function automatic logic [FRAME_BITS-1:0] build_frame(input psme_cmd_t cmd);
		logic [1:0] turnaround;
		turnaround = (cmd.op == OP_WRITE) ? WRITE_TURNAROUND : 2'h0;
		return {PREAMBLE_ONES, START_PATTERN, cmd.op, cmd.transceiver_address, // R20 R13 R14
			cmd.target_register_index, turnaround, cmd.data}; // R11 R12
	endfunction

	// System-domain state
	psme_cmd_t cmd_reg;
	psme_cmd_t launch_word;
	psme_cmd_t next_cmd;
	logic reg_hit;
	logic launch;
	logic launch_valid;
	logic req_tgl;
	logic done_sync;
	logic done_seen;
	logic done_event;
	logic done_edge;
	logic launch_reserved;
	logic ready_pending;
	logic [15:0] result_capture;

	// Link-domain state
	logic link_rst;
	logic req_sync;
	logic req_seen;
	logic done_tgl;
	logic mdio_sync;
	psme_link_state_t link_state;
	logic [FRAME_BITS-1:0] tx_shift;
	logic [15:0] rx_shift;
	logic [15:0] rd_hold;
	logic [5:0] bit_idx;
	logic is_read;
	logic [PW-1:0] phase;
	logic bit_end;
	logic run;
	logic frame_start;
	logic shift_step;

	// Address decode of the one word this block owns
	assign reg_hit = (bus_req.addr[7:2] == MGMT_CMD_OFFSET[7:2]); // R1
	assign launch = bus_req.wr && reg_hit && bus_req.be[LAUNCH_LANE]; // R2
	assign launch_valid = (next_cmd.op == OP_WRITE) || (next_cmd.op == OP_READ); // R10

	// Value the register takes on a write, reserved bits forced low
	always_comb begin
		next_cmd = psme_cmd_t'(merge_lanes(cmd_reg, bus_req.wdata, bus_req.be)); // R2
		next_cmd.reserved = 2'h0; // R6
	end

	// Command register: lanes latch on any write, hardware completion wins over software
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cmd_reg <= psme_cmd_t'(MGMT_CMD_RESET);
		end else begin
			if (bus_req.wr && reg_hit) begin
				cmd_reg <= next_cmd; // R9
			end
			if (ready_pending) begin
				cmd_reg.ready <= 1'b1; // R8 R17
				if (launch_word.op == OP_READ) begin
					cmd_reg.data <= result_capture; // R16 R19
				end
			end
		end
	end

	// Snapshot held stable while the link domain works on it
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			launch_word <= '0;
		end else if (launch) begin
			launch_word <= next_cmd; // R2
		end
	end

	// Launch toggle; reserved codes never reach the pins
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			req_tgl <= 1'b0;
		end else if (launch && launch_valid) begin
			req_tgl <= ~req_tgl; // R10
		end
	end

	// Completion toggle from the link comes back through two flops
	psme_sync #(
		.WIDTH(1)
	) u_done_sync (
		.clk(ref_clk),
		.rst(rst),
		.async_in(done_tgl),
		.sync_out(done_sync)
	);

	// Edge of the returned toggle, or an immediate finish for a reserved code
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			done_seen <= 1'b0;
		end else begin
			done_seen <= done_sync;
		end
	end

	// Qualified events shared by several processes
	assign launch_reserved = launch && !launch_valid; // R10
	assign done_edge = (done_sync != done_seen);
	assign done_event = done_edge || launch_reserved;

	// Read data is stable in rd_hold long before the toggle arrives
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			result_capture <= '0;
		end else if (done_edge) begin
			result_capture <= rd_hold; // R16
		end
	end

	// Interrupt one cycle ahead of the completion flag
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cycle_irq <= 1'b0;
			ready_pending <= 1'b0;
		end else begin
			cycle_irq <= done_event && (launch_reserved ? next_cmd.cycle_irq_enable
				: launch_word.cycle_irq_enable); // R7 R17
			ready_pending <= done_event; // R17
		end
	end

	// Register read port; other offsets read as zero
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			reg_rdata <= '0;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= bus_req.rd;
			if (bus_req.rd && reg_hit) begin
				reg_rdata <= {2'h0, cmd_reg[29:0]}; // R6
			end else begin
				reg_rdata <= '0;
			end
		end
	end

	// Reset carried into the link domain
	psme_sync #(
		.WIDTH(1)
	) u_rst_sync (
		.clk(serial_clk),
		.rst(1'b0),
		.async_in(rst),
		.sync_out(link_rst)
	);

	// Launch toggle into the link domain
	psme_sync #(
		.WIDTH(1)
	) u_req_sync (
		.clk(serial_clk),
		.rst(link_rst),
		.async_in(req_tgl),
		.sync_out(req_sync)
	);

	// Data pin input is asynchronous to the link clock
	psme_sync #(
		.WIDTH(1)
	) u_mdio_sync (
		.clk(serial_clk),
		.rst(link_rst),
		.async_in(mdio_in),
		.sync_out(mdio_sync)
	);

	// Divider runs only inside a frame, so the clock rests low between frames
	assign run = (link_state != LK_IDLE);

	// Frame start and bit step, shared by the sequencer and the shifters
	assign frame_start = (link_state == LK_IDLE) && (req_sync != req_seen);
	assign shift_step = (link_state == LK_SHIFT) && bit_end;

	// Divider for the management clock
	psme_bit_timer #(
		.DIV(DIV)
	) u_bit_timer (
		.clk(serial_clk),
		.rst(link_rst),
		.run(run),
		.phase(phase),
		.bit_end(bit_end)
	);

	// Frame sequencer
	always_ff @(posedge serial_clk) begin
		if (link_rst) begin
			link_state <= LK_IDLE;
			req_seen <= 1'b0;
			bit_idx <= '0;
			is_read <= 1'b0;
		end else begin
			case (link_state)
				LK_IDLE: begin
					if (frame_start) begin
						req_seen <= req_sync;
						is_read <= (launch_word.op == OP_READ);
						bit_idx <= '0;
						link_state <= LK_SHIFT;
					end
				end
				LK_SHIFT: begin
					if (bit_end) begin
						bit_idx <= bit_idx + 6'h01;
						if (bit_idx == LAST_BIT) begin
							link_state <= LK_TAIL; // R13
						end
					end
				end
				LK_TAIL: begin
					if (bit_end) begin
						link_state <= LK_IDLE; // R21
					end
				end
				default: begin
					link_state <= LK_IDLE;
				end
			endcase
		end
	end

	// Transmit shifter, one bit per management clock period
	always_ff @(posedge serial_clk) begin
		if (link_rst) begin
			tx_shift <= '0;
		end else if (frame_start) begin
			tx_shift <= build_frame(launch_word); // R13 R14
		end else if (shift_step) begin
			tx_shift <= {tx_shift[FRAME_BITS-2:0], 1'b0};
		end
	end

	// Pin drive; bits change while the clock is low
	always_ff @(posedge serial_clk) begin
		if (link_rst) begin
			mdio_out <= 1'b0;
			mdio_oe <= 1'b0;
		end else if (link_state == LK_SHIFT) begin
			mdio_out <= tx_shift[FRAME_BITS-1]; // R5
			mdio_oe <= !is_read || (bit_idx < DRIVEN_LIMIT); // R14
		end else begin
			mdio_out <= 1'b0;
			mdio_oe <= 1'b0; // R21
		end
	end

	// Clock high in the second half of each bit, low whenever idle
	always_ff @(posedge serial_clk) begin
		if (link_rst) begin
			mdc <= 1'b0;
		end else begin
			mdc <= (link_state == LK_SHIFT) && (phase >= HALF); // R4 R21
		end
	end

	// Sample the returned bits just before the rising edge view of each bit
	always_ff @(posedge serial_clk) begin
		if (link_rst) begin
			rx_shift <= '0;
		end else if (shift_step && is_read && bit_idx >= DATA_FIRST) begin
			rx_shift <= {rx_shift[14:0], mdio_sync}; // R5 R16
		end
	end

	// Result held and toggle flipped after the idle bit time
	always_ff @(posedge serial_clk) begin
		if (link_rst) begin
			rd_hold <= '0;
			done_tgl <= 1'b0;
		end else if (link_state == LK_TAIL && bit_end) begin
			rd_hold <= rx_shift; // R12
			done_tgl <= ~done_tgl;
		end
	end
endmodule // psme_engine

// [rtl/psme_pkg.sv]
// Shared constants, types and layouts of the management serial engine.
// What this block, its software and the transceiver do
// R1 - A 32-bit management command register sits at offset 10h of the control block.
// R2 - Writes of any width are accepted; only writing byte 13h launches a command.
// R3 - Software writes the top byte last when using partial writes.
// R4 - The device makes the management clock, never faster than 2.5 MHz.
// R5 - Device drives command bits on the data pin; transceiver drives status bits back.
// R6 - Bits 31:30 are reserved and always read as zero.
// R7 - With bit 29 set, an interrupt marks the end of the cycle; otherwise none.
// R8 - Bit 28 is set to one when a read or write finishes.
// R9 - Software clears the completion flag in the write that issues a command.
// R10 - Operation 01b writes, 10b reads; codes 00b and 11b are not used.
// R11 - Bits 25:21 carry transceiver address, 20:16 register index; both are sent.
// R12 - Bits 15:0 are shifted out on write and filled from the pin on read.
// R13 - Write frame: preamble, 01, 01, address, index, 10, sixteen data bits, idle.
// R14 - Read frame: preamble, 01, 10, address, index, then the data pin is released.
// R15 - On read the transceiver drives one zero, sixteen data bits, then idles.
// R16 - On read the first transceiver bit is dropped and the next sixteen stored.
// R17 - At frame end the interrupt is raised first, then the completion flag is set.
// R18 - Software issues a new command only after the previous completion flag.
// R19 - Software reads returned data only after the completion flag is set.
// R20 - The preamble is thirty-two consecutive one bits before the start pattern.
// R21 - The clock is divided down, held idle, and the pin released between frames.
package psme_pkg;

	// Register map of the control block
	localparam logic [7:0] MGMT_CMD_OFFSET = 8'h10;
	localparam int LAUNCH_LANE = 3;
	localparam logic [31:0] MGMT_CMD_RESET = 32'h1000_0000;

	// Operation codes
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_READ = 2'h2;

	// Frame layout, in bit times
	localparam logic [31:0] PREAMBLE_ONES = 32'hFFFF_FFFF;
	localparam logic [1:0] START_PATTERN = 2'h1;
	localparam logic [1:0] WRITE_TURNAROUND = 2'h2;
	localparam int FRAME_BITS = 64;
	localparam int READ_DRIVEN_BITS = 46;
	localparam int READ_DATA_FIRST = 48;

	// Management clock timing
	localparam int MDC_MAX_FREQ_KHZ = 2500;
	localparam int MDC_MIN_PERIOD_NS = 1000000 / MDC_MAX_FREQ_KHZ;
	localparam int LINK_CLK_PERIOD_NS = 160;
	localparam int MDC_DIV = ((MDC_MIN_PERIOD_NS + 2 * LINK_CLK_PERIOD_NS - 1) / (2 * LINK_CLK_PERIOD_NS)) * 2;

	// Command register layout
	typedef struct packed {
		logic [1:0] reserved;
		logic cycle_irq_enable;
		logic ready;
		logic [1:0] op;
		logic [4:0] transceiver_address;
		logic [4:0] target_register_index;
		logic [15:0] data;
	} psme_cmd_t;

	// Register access request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [3:0] be;
		logic [31:0] wdata;
	} psme_bus_req_t;

endpackage

// [rtl/psme_sync.sv]
// Two-flop synchroniser for levels and toggles.
module psme_sync #(
	parameter int WIDTH = 1
) (
	// Destination clock and reset
	input wire logic clk,
	input wire logic rst,
	// Signals to cross
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	import psme_pkg::*;

	logic [WIDTH-1:0] stage_one;

	if (WIDTH < 1) begin : g_bad_width
		$error("psme_sync: WIDTH must be at least 1");
	end

	// First flop feeds only the second one
	always_ff @(posedge clk) begin
		if (rst) begin
			stage_one <= '0;
			sync_out <= '0;
		end else begin
			stage_one <= async_in;
			sync_out <= stage_one;
		end
	end
endmodule // psme_sync

// [rtl/psme_bit_timer.sv]
// Bit-time phase counter for the divided management clock.
module psme_bit_timer #(
	parameter int DIV = 4
) (
	// Link clock and reset
	input wire logic clk,
	input wire logic rst,
	// Control and timing
	input wire logic run,
	output logic [$clog2(DIV)-1:0] phase,
	output logic bit_end
);
	import psme_pkg::*;

	localparam logic [$clog2(DIV)-1:0] LAST = ($clog2(DIV))'(DIV - 1);

	if (DIV < 2 || DIV % 2 != 0) begin : g_bad_div
		$error("psme_bit_timer: DIV must be even and at least 2");
	end

	assign bit_end = run && (phase == LAST);

	// Counter rests at zero while idle so every frame starts on a fresh bit
	always_ff @(posedge clk) begin
		if (rst || !run || bit_end) begin
			phase <= '0;
		end else begin
			phase <= phase + 1'b1;
		end
	end
endmodule // psme_bit_timer

// [testbench/psme_engine_properties.sv]
// Checker of register answers and management pin timing.
module psme_engine_properties #(
	parameter int DIV = 4
) (
	// Clocks and reset
	input logic ref_clk,
	input logic rst,
	input logic serial_clk,
	// Register port
	input psme_pkg::psme_bus_req_t bus_req,
	input logic [31:0] reg_rdata,
	input logic reg_rvalid,
	// Cycle interrupt
	input logic cycle_irq,
	// Management pins
	input logic mdc,
	input logic mdio_out,
	input logic mdio_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	import psme_pkg::*;

	logic [8:0] cnt;
	logic rd_op;
	int pos;

	// Link cycles since the pin was taken; saturates so long frames stay safe
	assign pos = int'(cnt);

	// Position counter and read flag taken from the opcode high bit
	always_ff @(posedge serial_clk) begin
		if (rst || !mdio_oe) begin
			cnt <= 9'h000;
			rd_op <= 1'b0;
		end else begin
			cnt <= (cnt == 9'h1FF) ? cnt : cnt + 9'h001;
			if (pos == 34 * DIV)
				rd_op <= mdio_out;
		end
	end

	// Clock halves; the counts hold for the default divider only
	sequence s_mdc_high;
		mdc [*2];
	endsequence
	sequence s_mdc_low;
		!mdc [*2];
	endsequence

	property p_rval; @(posedge ref_clk) disable iff (rst) bus_req.rd |=> reg_rvalid; endproperty
	a_rval: assert property (p_rval) else $error("read not answered");
	property p_unmap;
		@(posedge ref_clk) disable iff (rst) bus_req.rd && bus_req.addr[7:2] != 6'h04 |=> reg_rdata == 32'h0;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_rsv; @(posedge ref_clk) disable iff (rst) reg_rvalid |-> reg_rdata[31:30] == 2'b00; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits set");
	property p_mdc; @(posedge serial_clk) disable iff (rst) $rose(mdc) |-> s_mdc_high ##1 s_mdc_low; endproperty
	a_mdc: assert property (p_mdc) else $error("clock too fast");
	property p_stable; @(posedge serial_clk) disable iff (rst) mdc |-> $stable(mdio_out) && $stable(mdio_oe); endproperty
	a_stable: assert property (p_stable) else $error("pin moved while clock high");
	property p_pre; @(posedge serial_clk) disable iff (rst) mdio_oe && pos < 32 * DIV |-> mdio_out; endproperty
	a_pre: assert property (p_pre) else $error("preamble bit low");
	property p_start;
		@(posedge serial_clk) disable iff (rst)
		mdio_oe && (pos == 32 * DIV || pos == 33 * DIV) |-> mdio_out == (pos == 33 * DIV);
	endproperty
	a_start: assert property (p_start) else $error("bad start pattern");
	property p_ta;
		@(posedge serial_clk) disable iff (rst)
		mdio_oe && (pos == 46 * DIV || pos == 47 * DIV) |-> mdio_out == (pos == 46 * DIV);
	endproperty
	a_ta: assert property (p_ta) else $error("bad turnaround");
	property p_rel; @(posedge serial_clk) disable iff (rst) mdio_oe && rd_op |-> pos < 46 * DIV; endproperty
	a_rel: assert property (p_rel) else $error("read frame kept the pin");
	property p_irq_pulse; @(posedge ref_clk) disable iff (rst) cycle_irq |=> !cycle_irq; endproperty
	a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt longer than one cycle");
	property p_irq_idle; @(posedge ref_clk) disable iff (rst) cycle_irq |-> !mdio_oe && !mdc; endproperty
	a_irq_idle: assert property (p_irq_idle) else $error("interrupt before frame end");
endmodule // psme_engine_properties

bind psme_engine psme_engine_properties #(.DIV(DIV)) u_props (.ref_clk(ref_clk), .rst(rst),
	.serial_clk(serial_clk), .bus_req(bus_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
	.cycle_irq(cycle_irq), .mdc(mdc), .mdio_out(mdio_out), .mdio_oe(mdio_oe));

// [testbench/psme_phy_model.sv]
// Behavioural transceiver on the management pins with a small register file.
module psme_phy_model #(
	parameter logic [4:0] PHY_ADDR = 5'h03
) (
	// Management pins
	input wire logic mdc,
	input wire logic mdio,
	output logic out,
	output logic oe
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] mem [32];
	logic [12:0] hdr;
	logic [17:0] wd;
	int ones;

	// Registers start cleared, pin released
	initial begin
		out = 1'b0;
		oe = 1'b0;
		foreach (mem[i])
			mem[i] = 16'h0000;
	end

	// One frame a pass: hunt the preamble, take the header, answer or store
	always begin
		ones = 0;
		while (ones < 33) begin
			@(posedge mdc);
			ones = mdio ? (ones < 32 ? ones + 1 : 32) : (ones == 32 ? 33 : 0);
		end
		repeat (13) begin
			@(posedge mdc);
			hdr = {hdr[11:0], mdio};
		end
		if (hdr[11:10] == 2'b10 && hdr[9:5] == PHY_ADDR) begin
			@(posedge mdc);
			oe <= 1'b1;
			out <= 1'b0;
			for (int i = 15; i >= 0; i--) begin
				@(posedge mdc);
				out <= mem[hdr[4:0]][i];
			end
			@(posedge mdc);
			oe <= 1'b0;
		end else if (hdr[11:10] == 2'b01) begin
			repeat (18) begin
				@(posedge mdc);
				wd = {wd[16:0], mdio};
			end
			if (hdr[9:5] == PHY_ADDR)
				mem[hdr[4:0]] = wd[15:0];
		end
	end
endmodule // psme_phy_model

// [testbench/psme_engine_tb.sv]
// Self-checking bench for the management serial engine.
module psme_engine_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import psme_pkg::*;

	logic ref_clk = 1'b0;
	logic serial_clk = 1'b0;
	logic rst;
	psme_bus_req_t bus_req;
	logic [31:0] reg_rdata;
	logic reg_rvalid;
	logic cycle_irq;
	logic mdc;
	logic mdio_out;
	logic mdio_oe;
	logic phy_out;
	logic phy_oe;
	wire mdio_wire;
	int mismatches = 0;
	int n_compared = 0;
	int irq_cnt = 0;
	int e = 0;
	logic [31:0] r;
	logic [4:0] rg [3] = '{5'h05, 5'h1F, 5'h00};
	logic [15:0] dt [3] = '{16'hA5C3, 16'h0001, 16'h8000};

	// Two clocks of unrelated phase
	always #50 ref_clk = ~ref_clk;
	always #80 serial_clk = ~serial_clk;

	// Pull-up on the shared data line
	assign mdio_wire = mdio_oe ? mdio_out : (phy_oe ? phy_out : 1'b1);

	psme_engine dut (.ref_clk(ref_clk), .rst(rst), .bus_req(bus_req), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .cycle_irq(cycle_irq), .serial_clk(serial_clk), .mdc(mdc),
		.mdio_in(mdio_wire), .mdio_out(mdio_out), .mdio_oe(mdio_oe));
	psme_phy_model phy (.mdc(mdc), .mdio(mdio_wire), .out(phy_out), .oe(phy_oe));

	// Count end-of-cycle pulses
	always @(posedge ref_clk)
		if (cycle_irq === 1'b1)
			irq_cnt <= irq_cnt + 1;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		$display("compared %0d, mismatched %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic bus_wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
		@(posedge ref_clk);
		bus_req <= '{1'b1, 1'b0, a, be, d};
		@(posedge ref_clk);
		bus_req.wr <= 1'b0;
	endtask

	task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		bus_req <= '{1'b0, 1'b1, a, 4'hF, 32'h0};
		@(posedge ref_clk);
		bus_req.rd <= 1'b0;
		@(negedge ref_clk);
		check({31'h0, reg_rvalid}, 32'h1);
		d = reg_rdata;
	endtask

	// Launch a command, bytewise if asked, and poll until ready
	task automatic xfer(input logic [31:0] w, input bit bytes, output logic [31:0] d);
		int k;
		if (bytes) begin
			for (int b = 0; b < 3; b++)
				bus_wr(8'(16 + b), 4'(1 << b), w);
			repeat (20) @(posedge ref_clk);
			check({31'h0, mdio_oe}, 32'h0);
		end
		bus_wr(bytes ? 8'h13 : 8'h10, bytes ? 4'h8 : 4'hF, w);
		d = 32'h0;
		k = 0;
		while (d[28] !== 1'b1 && k < 3000) begin
			bus_rd(8'h10, d);
			k++;
		end
		check({31'h0, d[28]}, 32'h1);
		check({30'h0, mdc, mdio_oe}, 32'h0);
	endtask

	initial begin
		rst = 1'b1;
		bus_req = '0;
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		// Reset value; an unmapped write and read leave it alone
		bus_rd(8'h10, r);
		check(r, MGMT_CMD_RESET);
		bus_wr(8'h14, 4'hF, 32'hFFFF_FFFF);
		bus_rd(8'h14, r);
		check(r, 32'h0);
		bus_rd(8'h10, r);
		check(r, MGMT_CMD_RESET);
		$display("test reset done");
		// Write then read back at index 05h and both index edges, interrupt on and off
		for (int i = 0; i < 3; i++) begin
			xfer({2'b11, ~i[0], 1'b0, OP_WRITE, 5'h03, rg[i], dt[i]}, i == 0, r);
			e = e + (i[0] ? 0 : 1);
			check(r, {2'b00, ~i[0], 1'b1, OP_WRITE, 5'h03, rg[i], dt[i]});
			check(irq_cnt, e);
			xfer({2'b00, i[0], 1'b0, OP_READ, 5'h03, rg[i], 16'h0000}, 1'b0, r);
			e = e + (i[0] ? 1 : 0);
			check(r, {2'b00, i[0], 1'b1, OP_READ, 5'h03, rg[i], dt[i]});
			check(irq_cnt, e);
			$display("test transfer %0d done", i);
		end
		// Nobody answers at another address, so the pulled-up line reads ones
		xfer({4'h0, OP_READ, 5'h07, 5'h02, 16'h0000}, 1'b0, r);
		check({16'h0, r[15:0]}, 32'h0000_FFFF);
		$display("test address done");
		// Reserved code: no frame, completion and interrupt at once
		xfer({4'h2, 2'b00, 5'h03, 5'h01, 16'h1234}, 1'b0, r);
		e = e + 1;
		check(r, {4'h3, 2'b00, 5'h03, 5'h01, 16'h1234});
		check(irq_cnt, e);
		repeat (20) @(posedge ref_clk);
		check({31'h0, mdio_oe}, 32'h0);
		$display("test reserved code done");
		give_verdict();
	end

	// Cut a hang short
	initial begin
		#1000000;
		mismatches++;
		give_verdict();
	end
endmodule // psme_engine_tb
